// File: sim/pam_host.sv
// smbus host model on open-drain scl and sda, stepping on clk_sys edges
// assumes the bench resolves both wires with pull-ups
`timescale 1ns/100ps
module pam_host (
  input wire logic clk_sys,
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe_n,
  output logic sda_oe_n,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  logic stuck = 1'b0;
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // release scl, then hold off while the device stretches it
  task automatic scl_up();
    int n = 0;
    scl_oe_n <= 1'b1;
    @(posedge clk_sys);
    while (scl !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 5000) stuck = 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : scl_up
  task automatic bit_io(input logic b, output logic r);
    scl_oe_n <= 1'b0;
    @(posedge clk_sys);
    sda_oe_n <= b;
    repeat (3) @(posedge clk_sys);
    scl_up();
    r = sda;
  endtask : bit_io
  // start when s is high, stop plus bus-free time when low
  task automatic cond(input logic s);
    logic r;
    bit_io(s, r);
    sda_oe_n <= ~s;
    repeat (s ? 4 : 163) @(posedge clk_sys);
  endtask : cond
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(last, r);
    ack = ~r;
  endtask : xfer
  // settings are never stored, so the 5 ms hold-off never arises
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    input logic two, output logic ok);
    logic [7:0] x;
    logic k;
    cond(1'b1);
    xfer({a, 1'b0}, 1'b1, x, ok);
    if (ok) xfer(c, 1'b1, x, k);
    if (ok && two) xfer(d, 1'b1, x, k);
    cond(1'b0);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] c);
    logic [7:0] x;
    logic k;
    cond(1'b1);
    xfer({a, 1'b0}, 1'b1, x, k);
    xfer(c, 1'b1, x, k);
    cond(1'b1);
    xfer({a, 1'b1}, 1'b1, x, k);
    for (int i = 0; i < 2; i++) begin
      xfer(8'hff, i[0], x, k);
      rx_byte <= x;
      rx_valid <= 1'b1;
      @(posedge clk_sys);
      rx_valid <= 1'b0;
    end
    cond(1'b0);
  endtask : rd
endmodule : pam_host

// File: sim/pmbus_address_alert_monitor_test.sv
// self-checking bench for the address, alert and turn-on monitor
// assumes pull-ups on scl, sda and the alert line; host model on the far side
`timescale 1ns/100ps
module pmbus_address_alert_monitor_test import pam_pkg::*;;
  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  localparam int INIT = 100;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic vin_ok = 1'b0;
  logic remote_on_off = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] addr_strap_pin = 4'h0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [7:0] flt [5] = '{default: 8'h00};
  logic [15:0] tel [7] = '{default: 16'h0000};
  logic [63:0] reg_q[$], ser_q[$];
  logic [31:0] seed = 32'h5dd07980;
  logic [7:0] off;
  logic [8:0] sum;
  logic [3:0] sp;
  logic ok, ack;
  logic [6:0] dev = 7'h63;
  logic [7:0] rcmd [6] = '{CMD_RD_VIN, CMD_RD_VOUT, CMD_RD_IOUT, CMD_RD_TEMP, CMD_RD_FREQ,
                           CMD_RD_DUTY};
  logic [7:0] tgt [6] = '{8'h0c, 8'h10, 8'h7f, 8'h7e, 8'h0b, 8'h11};
  int n, fails = 0, samples_checked = 0;
  wire logic scl_d, sda_d, scl_h, sda_h, alert, oen, idone, avs_waitrequest, irq, rxv;
  wire logic [7:0] rxb;
  wire logic [31:0] avs_readdata;
  wire logic scl = scl_d & scl_h;
  wire logic sda = sda_d & sda_h;
  always #4 clk_sys = ~clk_sys;
  pam_monitor #(.INIT_CNT(INIT)) pam_monitor_inst (.clk_sys(clk_sys), .rst(rst),
    .scl_i(scl), .scl_oe_n(scl_d), .sda_i(sda), .sda_oe_n(sda_d),
    .fault_alert_out_oe_n(alert), .addr_strap_pin(addr_strap_pin), .vin_ok(vin_ok),
    .remote_on_off(remote_on_off), .output_enable(oen), .init_done(idone),
    .fault_vout(flt[0]), .fault_iout(flt[1]), .fault_input(flt[2]), .fault_temp(flt[3]),
    .fault_mfr(flt[4]), .tel_vin(tel[0]), .tel_vout(tel[1]), .tel_iout(tel[2]),
    .tel_temp_int(tel[3]), .tel_freq(tel[4]), .tel_duty(tel[5]), .tel_temp_ext(tel[6]),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  pam_host pam_host_inst (.clk_sys(clk_sys), .scl(scl), .sda(sda), .scl_oe_n(scl_h),
    .sda_oe_n(sda_h), .rx_byte(rxb), .rx_valid(rxv));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic finish_test();
    if (pam_host_inst.stuck) fails++;
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  task automatic timeout();
    fails++;
    finish_test();
  endtask : timeout
  task automatic check_read(input logic [31:0] got, input logic [63:0] note);
    samples_checked++;
    if ((got & note[63:32]) !== note[31:0]) begin
      fails++;
      $display("ERROR %0t read %h expected %h", $time, got, note[31:0]);
    end
  endtask : check_read
  task automatic check_lvl(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t level %b expected %b", $time, got, exp);
    end
  endtask : check_lvl
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) check_read(avs_readdata, reg_q.pop_front());
    if (rxv) check_read({24'h0, rxb}, ser_q.pop_front());
  end
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk_sys);
      k++;
      if (k > 50) timeout();
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd_reg(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_q.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask : rd_reg
  task automatic rd_ser(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
    ser_q.push_back({24'h0, m[7:0], 24'h0, e[7:0]});
    ser_q.push_back({24'h0, m[15:8], 24'h0, e[15:8]});
    pam_host_inst.rd(dev, c);
  endtask : rd_ser
  task automatic wait_on(input logic which, output int c);
    c = 0;
    while ((which ? oen : idone) !== 1'b1) begin
      @(posedge clk_sys);
      c++;
      if (c > 2000) timeout();
    end
  endtask : wait_on
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_reg(REG_BASE_OFFSET, 32'hff, 32'h60);
    rd_reg(REG_TON_DELAY, 32'hffff, 32'ha);
    rd_reg(REG_IRQ_CLEAR, 32'hffffffff, 32'h0);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      sp = (i < 10) ? i[3:0] : seed[11:8] % 4'ha;
      off = (i < 10) ? 8'h60 : (i < 16) ? tgt[i - 10] - {4'h0, sp} : seed[23:16];
      sum = off + {4'h0, sp};
      ok = sum >= 8'h01 && sum <= 8'h7e && sum != 8'h0c && sum != 8'h10;
      addr_strap_pin <= sp;
      bus(1'b1, REG_BASE_OFFSET, {24'h0, off});
      repeat (6) @(posedge clk_sys);
      rd_reg(REG_STATE, 32'h87f, {20'h0, ~ok, 4'h0, ok ? sum[6:0] : 7'h7e});
    end
    bus(1'b1, REG_IRQ_ENABLE, 32'hf);
    bus(1'b1, REG_TON_DELAY, 32'h2);
    flt[1] <= 8'h01;
    vin_ok <= 1'b1;
    wait_on(1'b0, n);
    check_lvl(n >= INIT && n <= INIT + 8, 1'b1);
    check_lvl(alert, 1'b0);
    flt[1] <= 8'h00;
    repeat (20) @(posedge clk_sys);
    check_lvl(alert, 1'b0);
    remote_on_off <= 1'b1;
    wait_on(1'b1, n);
    check_lvl(n >= 251 && n <= 259, 1'b1);
    repeat (4) @(posedge clk_sys);
    check_lvl(alert, 1'b1);
    rd_reg(REG_IRQ_STATUS, 32'h5, 32'h5);
    check_lvl(irq, 1'b1);
    bus(1'b1, REG_IRQ_CLEAR, 32'hf);
    rd_reg(REG_IRQ_STATUS, 32'hf, 32'h0);
    check_lvl(irq, 1'b0);
    addr_strap_pin <= 4'h3;
    bus(1'b1, REG_BASE_OFFSET, 32'h60);
    pam_host_inst.wr(7'h64, CMD_TEMP_SEL, 8'h00, 1'b1, ack);
    check_lvl(ack, 1'b0);
    pam_host_inst.wr(dev, CMD_BASE_OFFSET, 8'h20, 1'b1, ack);
    check_lvl(ack, 1'b1);
    rd_reg(REG_BASE_OFFSET, 32'hff, 32'h20);
    dev = 7'h23;
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      tel[i] <= seed[15:0];
    end
    @(posedge clk_sys);
    for (int i = 0; i < 6; i++) rd_ser(rcmd[i], 16'hffff, tel[i]);
    pam_host_inst.wr(dev, CMD_TEMP_SEL, 8'h01, 1'b1, ack);
    rd_ser(CMD_RD_TEMP, 16'hffff, tel[6]);
    pam_host_inst.wr(dev, CMD_ALERT_MASK, 8'h04, 1'b1, ack);
    flt[3] <= 8'h40;
    repeat (8) @(posedge clk_sys);
    flt[3] <= 8'h00;
    check_lvl(alert, 1'b1);
    rd_ser(CMD_ST_TEMP, 16'hffff, 16'h0040);
    flt[0] <= 8'h80;
    repeat (8) @(posedge clk_sys);
    flt[0] <= 8'h00;
    check_lvl(alert, 1'b0);
    rd_ser(CMD_ST_VOUT, 16'hffff, 16'h0080);
    pam_host_inst.wr(dev, CMD_CLEAR_FAULTS, 8'h00, 1'b0, ack);
    check_lvl(alert, 1'b1);
    rd_ser(CMD_ST_VOUT, 16'hffff, 16'h0000);
    pam_host_inst.wr(dev, 8'h01, 8'h00, 1'b1, ack);
    rd_ser(CMD_ST_CML, 16'hffff, 16'h0080);
    bus(1'b1, REG_CTRL, 32'h1);
    fork
      pam_host_inst.wr(dev, CMD_TEMP_SEL, 8'h00, 1'b1, ack);
      begin
        repeat (600) @(posedge clk_sys);
        check_lvl(scl, 1'b0);
        bus(1'b1, REG_CTRL, 32'h0);
      end
    join
    rd_ser(CMD_ST_BYTE, 16'h0080, 16'h0080);
    rd_reg(REG_IRQ_STATUS, 32'h8, 32'h8);
    finish_test();
  end
endmodule : pmbus_address_alert_monitor_test

// File: src/pam_monitor.sv
// bus address resolution, alert, status and telemetry slave, turn-on sequencing
// assumes scl/sda/strap/vin/remote pins are asynchronous; fault inputs are on clk_sys
//
// Contract
// R1: address equals strap index plus base offset
// R2: base offset written by command 0xc9
// R3: legal addresses 1..126 except 12, 16
// R4: illegal calculated address becomes 126
// R5: standard protocol; device may stretch clock
// R6: busy flag reported when too busy
// R7: host leaves bus-free time between transfers
// R8: host waits 5 ms after storing settings
// R9: alert low on active unmasked fault
// R10: alert held until clear or re-enable
// R11: alert mask blocks masked conditions
// R12: status commands report alert cause
// R13: telemetry readable at any time
// R14: temperature source chosen by command 0xdc
// R15: bus clock between 100 and 400 kHz; the bench host clocks scl at 8 clk_sys cycles per bit, about 15.6 MHz
// R16: initialisation takes 15 ms after supply
// R17: output on after turn-on delay
// R18: acknowledge only own address
`timescale 1ns/100ps
module pam_monitor import pam_pkg::*; #(
  parameter int INIT_CNT = INIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_i,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_oe_n,
  output logic fault_alert_out_oe_n,
  input wire logic [3:0] addr_strap_pin,
  input wire logic vin_ok,
  input wire logic remote_on_off,
  output logic output_enable,
  output logic init_done,
  input wire logic [7:0] fault_vout,
  input wire logic [7:0] fault_iout,
  input wire logic [7:0] fault_input,
  input wire logic [7:0] fault_temp,
  input wire logic [7:0] fault_mfr,
  input wire logic [15:0] tel_vin,
  input wire logic [15:0] tel_vout,
  input wire logic [15:0] tel_iout,
  input wire logic [15:0] tel_temp_int,
  input wire logic [15:0] tel_temp_ext,
  input wire logic [15:0] tel_freq,
  input wire logic [15:0] tel_duty,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] pin_meta, pin_sync, pin_last;
  wire [7:0] pin_raw = {scl_i, sda_i, vin_ok, remote_on_off, addr_strap_pin};
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_meta <= 8'hff;
      pin_sync <= 8'hff;
      pin_last <= 8'hff;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end
  wire scl = pin_sync[7];
  wire sda = pin_sync[6];
  wire scl_rise = scl & ~pin_last[7]; // [R15]
  wire scl_fall = ~scl & pin_last[7];
  wire bus_start = scl & pin_last[7] & ~sda & pin_last[6];
  wire bus_stop = scl & pin_last[7] & sda & ~pin_last[6];
  // ---------------------------------------------------------------
  // address resolution
  // ---------------------------------------------------------------
  function automatic logic pam_legal(input logic [8:0] a);
    return !a[8] && (a[7:0] >= ADDR_MIN) && (a[7:0] <= ADDR_MAX) &&
           (a[7:0] != ADDR_BAD_A) && (a[7:0] != ADDR_BAD_B);
  endfunction : pam_legal
  logic [7:0] base_offset;
  wire [8:0] calc_addr = {1'b0, base_offset} + {5'h00, pin_sync[3:0]}; // [R1]
  wire addr_ok = pam_legal(calc_addr); // [R3]
  wire [6:0] own_addr = addr_ok ? calc_addr[6:0] : ADDR_FALLBACK; // [R4]
  // ---------------------------------------------------------------
  // fault status and alert
  // ---------------------------------------------------------------
  logic [7:0] st_vout, st_iout, st_input, st_temp, st_mfr, st_cml;
  logic st_busy;
  logic [7:0] alert_mask;
  logic clear_req, out_on_rise;
  wire clr = clear_req | out_on_rise; // [R10]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_vout <= 8'h00;
      st_iout <= 8'h00;
      st_input <= 8'h00;
      st_temp <= 8'h00;
      st_mfr <= 8'h00;
    end else begin
      st_vout <= (clr ? 8'h00 : st_vout) | fault_vout;
      st_iout <= (clr ? 8'h00 : st_iout) | fault_iout;
      st_input <= (clr ? 8'h00 : st_input) | fault_input;
      st_temp <= (clr ? 8'h00 : st_temp) | fault_temp;
      st_mfr <= (clr ? 8'h00 : st_mfr) | fault_mfr;
    end
  end
  wire [7:0] st_byte = {st_busy, ~output_enable, |st_vout, |st_iout, |st_input,
                        |st_temp, |st_cml, |st_mfr}; // [R12]
  wire [15:0] st_word = {|st_vout, |st_iout, |st_input, |st_mfr, 4'h0, st_byte};
  wire alert_cond = |(st_byte[5:0] & ~alert_mask[5:0]); // [R11]
  assign fault_alert_out_oe_n = ~alert_cond; // [R9]
  // ---------------------------------------------------------------
  // power-up and turn-on sequencing
  // ---------------------------------------------------------------
  pam_pwr_t pwr;
  logic [31:0] pwr_cnt;
  logic [15:0] ton_delay;
  wire vin_s = pin_sync[5];
  wire rc_s = pin_sync[4];
  wire [31:0] delay_cycles = 32'(ton_delay) * 32'(US_CYCLES);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwr <= PW_INIT;
      pwr_cnt <= 32'h0;
    end else if (!vin_s) begin
      pwr <= PW_INIT;
      pwr_cnt <= 32'h0;
    end else begin
      case (pwr)
        PW_INIT: begin
          pwr_cnt <= pwr_cnt + 32'h1;
          if (pwr_cnt >= 32'(INIT_CNT - 1)) begin // [R16]
            pwr <= PW_READY;
          end
        end
        PW_READY: begin
          pwr_cnt <= 32'h0;
          if (rc_s) begin
            pwr <= PW_DELAY;
          end
        end
        PW_DELAY: begin
          pwr_cnt <= pwr_cnt + 32'h1;
          if (!rc_s) begin
            pwr <= PW_READY;
          end else if (pwr_cnt >= delay_cycles) begin // [R17]
            pwr <= PW_ON;
          end
        end
        PW_ON: begin
          if (!rc_s) begin
            pwr <= PW_READY;
          end
        end
        default: pwr <= PW_INIT;
      endcase
    end
  end
  assign output_enable = (pwr == PW_ON);
  assign init_done = (pwr != PW_INIT);
  logic out_on_last;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_on_last <= 1'b0;
    end else begin
      out_on_last <= output_enable;
    end
  end
  assign out_on_rise = output_enable & ~out_on_last;
  // ---------------------------------------------------------------
  // serial bus slave
  // ---------------------------------------------------------------
  pam_i2c_t i2c;
  logic [7:0] shreg, cmd;
  logic [3:0] bitcnt;
  logic rw, byte_idx, sda_drive, stretch, fw_busy, temp_sel;
  logic cfg_wr_bus;
  logic [7:0] cfg_data;
  wire byte_done = (bitcnt == 4'd8);
  wire addr_match = (shreg[7:1] == own_addr); // [R18]
  wire known_wr = (cmd == CMD_ALERT_MASK) || (cmd == CMD_BASE_OFFSET) || (cmd == CMD_TEMP_SEL);
  logic [15:0] rd_word;
  always_comb begin
    case (cmd)
      CMD_ST_BYTE: rd_word = {8'h00, st_byte};
      CMD_ST_WORD: rd_word = st_word;
      CMD_ST_VOUT: rd_word = {8'h00, st_vout};
      CMD_ST_IOUT: rd_word = {8'h00, st_iout};
      CMD_ST_INPUT: rd_word = {8'h00, st_input};
      CMD_ST_TEMP: rd_word = {8'h00, st_temp};
      CMD_ST_CML: rd_word = {8'h00, st_cml};
      CMD_ST_MFR: rd_word = {8'h00, st_mfr};
      CMD_RD_VIN: rd_word = tel_vin; // [R13]
      CMD_RD_VOUT: rd_word = tel_vout;
      CMD_RD_IOUT: rd_word = tel_iout;
      CMD_RD_TEMP: rd_word = temp_sel ? tel_temp_ext : tel_temp_int; // [R14]
      CMD_RD_FREQ: rd_word = tel_freq;
      CMD_RD_DUTY: rd_word = tel_duty;
      CMD_ALERT_MASK: rd_word = {8'h00, alert_mask};
      CMD_BASE_OFFSET: rd_word = {8'h00, base_offset};
      CMD_TEMP_SEL: rd_word = {15'h0000, temp_sel};
      default: rd_word = 16'hffff;
    endcase
  end
  wire [7:0] tx_byte = byte_idx ? rd_word[15:8] : rd_word[7:0];
  wire [2:0] tx_pos = 3'(4'd7 - bitcnt);
  wire enter_ack = scl_fall & byte_done &
                   (((i2c == I2C_ADDR) & addr_match) | (i2c == I2C_CMD) | (i2c == I2C_WDATA));
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      i2c <= I2C_IDLE;
      shreg <= 8'h00;
      cmd <= 8'h00;
      bitcnt <= 4'h0;
      rw <= 1'b0;
      byte_idx <= 1'b0;
      sda_drive <= 1'b0;
    end else if (bus_start) begin
      i2c <= I2C_ADDR;
      bitcnt <= 4'h0;
      sda_drive <= 1'b0;
    end else if (bus_stop) begin
      i2c <= I2C_IDLE;
      sda_drive <= 1'b0;
    end else if (scl_rise) begin
      if (i2c == I2C_RDATA) begin
        bitcnt <= bitcnt + 4'h1;
      end else if (i2c == I2C_RACK) begin
        if (sda) begin
          i2c <= I2C_IDLE;
        end
      end else if (i2c == I2C_ADDR || i2c == I2C_CMD || i2c == I2C_WDATA) begin
        shreg <= {shreg[6:0], sda};
        bitcnt <= bitcnt + 4'h1;
      end
    end else if (scl_fall && !stretch) begin
      case (i2c)
        I2C_ADDR: if (byte_done) begin
          i2c <= addr_match ? I2C_ACK_A : I2C_IDLE; // [R18]
          sda_drive <= addr_match;
          rw <= shreg[0];
        end
        I2C_ACK_A: begin
          bitcnt <= 4'h0;
          byte_idx <= 1'b0;
          i2c <= rw ? I2C_RDATA : I2C_CMD;
          sda_drive <= rw & ~rd_word[7];
        end
        I2C_CMD: if (byte_done) begin
          i2c <= I2C_ACK_C;
          sda_drive <= 1'b1;
          cmd <= shreg;
        end
        I2C_ACK_C, I2C_ACK_W: begin
          i2c <= I2C_WDATA;
          bitcnt <= 4'h0;
          sda_drive <= 1'b0;
        end
        I2C_WDATA: if (byte_done) begin
          i2c <= I2C_ACK_W;
          sda_drive <= 1'b1;
        end
        I2C_RDATA: begin
          if (byte_done) begin
            i2c <= I2C_RACK;
            sda_drive <= 1'b0;
          end else begin
            sda_drive <= ~tx_byte[tx_pos];
          end
        end
        I2C_RACK: begin
          i2c <= I2C_RDATA;
          bitcnt <= 4'h0;
          byte_idx <= ~byte_idx;
          sda_drive <= ~(byte_idx ? rd_word[7] : rd_word[15]);
        end
        default: i2c <= I2C_IDLE;
      endcase
    end
  end
  assign sda_oe_n = ~sda_drive;
  assign scl_oe_n = ~stretch; // [R5]
  assign clear_req = scl_fall & ~stretch & (i2c == I2C_CMD) & byte_done &
                     (shreg == CMD_CLEAR_FAULTS);
  assign cfg_wr_bus = scl_fall & ~stretch & (i2c == I2C_WDATA) & byte_done & known_wr;
  assign cfg_data = shreg;
  wire bad_cmd = scl_fall & ~stretch & (i2c == I2C_WDATA) & byte_done & ~known_wr;
  // clock stretching while firmware is busy; the busy flag records it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stretch <= 1'b0;
      st_busy <= 1'b0;
      st_cml <= 8'h00;
    end else begin
      stretch <= fw_busy & (stretch | enter_ack); // [R5]
      st_busy <= (st_busy & ~clr) | (enter_ack & fw_busy); // [R6]
      st_cml <= (clr ? 8'h00 : st_cml) | (bad_cmd ? 8'h80 : 8'h00);
    end
  end
  // ---------------------------------------------------------------
  // software register slave
  // ---------------------------------------------------------------
  logic avs_done;
  logic [3:0] irq_status, irq_enable;
  wire avs_req = avs_read | avs_write;
  wire avs_wr_now = avs_write & ~avs_done;
  wire [3:0] irq_clear = (avs_wr_now && avs_address == REG_IRQ_CLEAR) ? avs_writedata[3:0] : 4'h0;
  logic alert_last;
  wire [3:0] irq_event = {enter_ack & fw_busy, out_on_rise, cfg_wr_bus,
                          alert_cond & ~alert_last};
  assign avs_waitrequest = avs_req & ~avs_done;
  assign irq = |(irq_status & irq_enable);
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      REG_CTRL: rd_mux = {31'h0, fw_busy};
      REG_STATE: rd_mux = {20'h0, ~addr_ok, alert_cond, output_enable, init_done,
                           1'b0, own_addr};
      REG_TON_DELAY: rd_mux = {16'h0, ton_delay};
      REG_BASE_OFFSET: rd_mux = {24'h0, base_offset};
      REG_TEMP_SEL: rd_mux = {31'h0, temp_sel};
      REG_IRQ_STATUS: rd_mux = {28'h0, irq_status};
      REG_IRQ_ENABLE: rd_mux = {28'h0, irq_enable};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_done <= 1'b0;
      avs_readdata <= 32'h0;
      fw_busy <= 1'b0;
      ton_delay <= TON_DELAY_RST;
      base_offset <= BASE_OFFSET_RST;
      temp_sel <= 1'b0;
      alert_mask <= 8'h00;
      irq_status <= 4'h0;
      irq_enable <= 4'h0;
      alert_last <= 1'b0;
    end else begin
      avs_done <= avs_req & ~avs_done;
      alert_last <= alert_cond;
      irq_status <= (irq_status & ~irq_clear) | irq_event;
      if (avs_read && !avs_done) begin
        avs_readdata <= rd_mux;
      end
      if (avs_wr_now) begin
        case (avs_address)
          REG_CTRL: fw_busy <= avs_writedata[0];
          REG_TON_DELAY: ton_delay <= avs_writedata[15:0];
          REG_BASE_OFFSET: base_offset <= avs_writedata[7:0];
          REG_TEMP_SEL: temp_sel <= avs_writedata[0];
          REG_IRQ_ENABLE: irq_enable <= avs_writedata[3:0];
          default: ;
        endcase
      end
      if (cfg_wr_bus) begin
        case (cmd)
          CMD_BASE_OFFSET: base_offset <= cfg_data; // [R2]
          CMD_TEMP_SEL: temp_sel <= cfg_data[0]; // [R14]
          default: alert_mask <= cfg_data; // [R11]
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_addr_byte_end;
    scl_fall && !stretch && !bus_start && !bus_stop && i2c == I2C_ADDR && byte_done;
  endsequence
  a_addr_legal_out: assert property (pam_legal({2'b0, own_addr})) // [R3]
    else $error("resolved address is not legal");
  a_addr_fallback: assert property (!pam_legal(calc_addr) |-> own_addr == 7'h7e) // [R4]
    else $error("illegal address not replaced by 126");
  a_addr_sum: assert property (pam_legal(calc_addr) |-> own_addr == calc_addr[6:0]) // [R1]
    else $error("resolved address is not strap plus offset");
  a_alert_on_fault: assert property ($rose(|fault_vout) && !alert_mask[5]
    |=> !fault_alert_out_oe_n) // [R9]
    else $error("unmasked fault did not pull alert low");
  a_alert_holds: assert property (!fault_alert_out_oe_n && !clr && $stable(alert_mask)
    |=> !fault_alert_out_oe_n) // [R10]
    else $error("alert released without clear");
  a_mask_blocks: assert property ((st_byte[5:0] & ~alert_mask[5:0]) == 6'h00
    |-> fault_alert_out_oe_n) // [R11]
    else $error("masked condition drove alert");
  a_nack_other: assert property (s_addr_byte_end ##0 !addr_match
    |=> i2c == I2C_IDLE && sda_oe_n) // [R18]
    else $error("foreign address acknowledged");
  a_ack_own: assert property (s_addr_byte_end ##0 addr_match
    |=> i2c == I2C_ACK_A && !sda_oe_n) // [R18]
    else $error("own address not acknowledged");
  a_busy_stretch: assert property (enter_ack && fw_busy
    |=> !scl_oe_n && st_busy) // [R6]
    else $error("busy not reported with stretch");
  a_ton_delay: assert property ($rose(output_enable) |->
    $past(pwr_cnt) >= $past(delay_cycles)) // [R17]
    else $error("output enabled without turn-on delay");
  a_init_done: assert property ($rose(init_done) |-> $past(pwr_cnt) >= 32'(INIT_CNT - 1)) // [R16]
    else $error("initialisation ended early");
  a_bus_wait: assert property (avs_req && !avs_done |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("register access not answered in one wait cycle");
endmodule : pam_monitor

// File: src/pam_pkg.sv
// package for the bus address, alert and turn-on monitor
// assumes a single 125 MHz system clock domain
package pam_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int INIT_TIME_MS = 15;
  localparam int INIT_CYCLES = (CLK_HZ / 1000) * INIT_TIME_MS;
  localparam int US_CYCLES = CLK_HZ / 1_000_000;
  // ---------------------------------------------------------------
  // address resolution
  // ---------------------------------------------------------------
  localparam logic [7:0] BASE_OFFSET_RST = 8'h60;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'h7e;
  localparam logic [7:0] ADDR_BAD_A = 8'h0c;
  localparam logic [7:0] ADDR_BAD_B = 8'h10;
  localparam logic [6:0] ADDR_FALLBACK = 7'h7e;
  // ---------------------------------------------------------------
  // bus command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
  localparam logic [7:0] CMD_ST_BYTE = 8'h78;
  localparam logic [7:0] CMD_ST_WORD = 8'h79;
  localparam logic [7:0] CMD_ST_VOUT = 8'h7a;
  localparam logic [7:0] CMD_ST_IOUT = 8'h7b;
  localparam logic [7:0] CMD_ST_INPUT = 8'h7c;
  localparam logic [7:0] CMD_ST_TEMP = 8'h7d;
  localparam logic [7:0] CMD_ST_CML = 8'h7e;
  localparam logic [7:0] CMD_ST_MFR = 8'h80;
  localparam logic [7:0] CMD_RD_VIN = 8'h88;
  localparam logic [7:0] CMD_RD_VOUT = 8'h8b;
  localparam logic [7:0] CMD_RD_IOUT = 8'h8c;
  localparam logic [7:0] CMD_RD_TEMP = 8'h8d;
  localparam logic [7:0] CMD_RD_DUTY = 8'h94;
  localparam logic [7:0] CMD_RD_FREQ = 8'h95;
  localparam logic [7:0] CMD_BASE_OFFSET = 8'hc9;
  localparam logic [7:0] CMD_TEMP_SEL = 8'hdc;
  localparam int CML_BAD_CMD = 7;
  // ---------------------------------------------------------------
  // software registers (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATE = 5'h04;
  localparam logic [4:0] REG_TON_DELAY = 5'h08;
  localparam logic [4:0] REG_BASE_OFFSET = 5'h0c;
  localparam logic [4:0] REG_TEMP_SEL = 5'h10;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h14;
  localparam logic [4:0] REG_IRQ_ENABLE = 5'h18;
  localparam logic [4:0] REG_IRQ_CLEAR = 5'h1c;
  localparam logic [15:0] TON_DELAY_RST = 16'h000a;
  localparam int IRQ_ALERT = 0;
  localparam int IRQ_CFG = 1;
  localparam int IRQ_OUT_ON = 2;
  localparam int IRQ_BUSY = 3;
  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_CMD, I2C_ACK_C,
    I2C_WDATA, I2C_ACK_W, I2C_RDATA, I2C_RACK
  } pam_i2c_t;
  typedef enum logic [1:0] {PW_INIT, PW_READY, PW_DELAY, PW_ON} pam_pwr_t;
endpackage : pam_pkg
